// ==== logic/switch_config_pkg.sv ====
// Constants shared by the switch configuration register banks.
package switch_config_pkg;

  // Bank select values on the access port.
  localparam logic BANK_CORE = 1'b0;
  localparam logic BANK_NODE = 1'b1;

  // Processor switch bank offsets.
  localparam logic [7:0] CORE_ID_OFS = 8'h00;
  localparam logic [7:0] CORE_RES_A_OFS = 8'h01;
  localparam logic [7:0] CORE_RES_B_OFS = 8'h02;
  localparam logic [7:0] CORE_PERM_OFS = 8'h04;
  localparam logic [7:0] CORE_DBG_IRQ_OFS = 8'h05;
  localparam logic [7:0] CORE_CLK_DIV_OFS = 8'h06;
  localparam logic [7:0] CORE_SECURITY_OFS = 8'h07;
  localparam logic [7:0] CORE_SCRATCH_OFS = 8'h20;
  localparam logic [7:0] CORE_PC_OFS = 8'h40;
  localparam logic [7:0] CORE_SR_OFS = 8'h60;

  // Interconnect bank offsets.
  localparam logic [7:0] NODE_ID_REG_OFS = 8'h00;
  localparam logic [7:0] NODE_RES_OFS = 8'h01;
  localparam logic [7:0] NODE_CFG_OFS = 8'h04;
  localparam logic [7:0] NODE_IDENT_OFS = 8'h05;
  localparam logic [7:0] NODE_PLL_OFS = 8'h06;
  localparam logic [7:0] NODE_SW_RATIO_OFS = 8'h07;
  localparam logic [7:0] NODE_REF_RATIO_OFS = 8'h08;
  localparam logic [7:0] NODE_DIR_OFS = 8'h0c;

  // Bit positions of permission and node configuration fields.
  localparam int PERM_NO_DBG_WRITE_BIT = 0;
  localparam int PERM_NO_REMOTE_BIT = 8;
  localparam int PERM_FREEZE_BIT = 31;
  localparam int CFG_SHORT_HDR_BIT = 0;
  localparam int CFG_PLL_LOCK_BIT = 8;
  localparam int CFG_FREEZE_BIT = 31;
  localparam int DBG_IRQ_BIT = 0;

  // PLL field positions.
  localparam int PLL_REF_LSB = 0;
  localparam int PLL_REF_MSB = 5;
  localparam int PLL_FB_LSB = 8;
  localparam int PLL_FB_MSB = 20;
  localparam int PLL_OUT_LSB = 23;
  localparam int PLL_OUT_MSB = 25;

  // Identification values; these values are arbitrary.
  localparam logic [7:0] CORE_VERSION = 8'h5a;
  localparam logic [7:0] CORE_REVISION = 8'h2c;
  localparam logic [7:0] NODE_VERSION = 8'h6e;
  localparam logic [7:0] NODE_REVISION = 8'h17;

  // Resource counts reported by the banks.
  localparam logic [7:0] NUM_THREADS = 8'h08;
  localparam logic [7:0] NUM_SYNCS = 8'h07;
  localparam logic [7:0] NUM_LOCKS = 8'h04;
  localparam logic [7:0] NUM_CHANENDS = 8'h20;
  localparam logic [7:0] NUM_TIMERS = 8'h0a;
  localparam logic [7:0] NUM_CLK_BLOCKS = 8'h06;
  localparam logic [7:0] NUM_INT_LINKS = 8'h04;
  localparam logic [7:0] NUM_CORES = 8'h01;
  localparam logic [7:0] NUM_EXT_LINKS = 8'h08;

  // Reset values of writable registers.
  localparam logic [31:0] CORE_PERM_RESET = 32'h0000_0000;
  localparam logic [31:0] CORE_CLK_DIV_RESET = 32'h0000_0000;
  localparam logic [31:0] NODE_CFG_RESET = 32'h0000_0000;
  localparam logic [15:0] NODE_ID_RESET = 16'h0000;
  localparam logic [31:0] PLL_RESET = 32'h0000_0000;
  localparam logic [15:0] SW_RATIO_RESET = 16'h0000;
  localparam logic [15:0] REF_RATIO_RESET = 16'h0003;
  localparam logic [31:0] DIR_RESET = 32'h0000_0000;

  // Access sequencer states, Gray coded from ST_IDLE to ST_REPLY; the return to ST_IDLE flips both bits.
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_DECODE = 2'b01,
    ST_REPLY = 2'b11
  } access_state_e;

endpackage : switch_config_pkg

// ==== logic/clock_rate_divider.sv ====
// Divides the system clock into a one-cycle enable every ratio plus one.
`timescale 1ns/1ps
module clock_rate_divider (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic [15:0] ratio_i,
  output logic enable_o
);

  logic [15:0] count;

  // The count restarts on a pulse; ratio_i is compared every cycle, so a new ratio takes hold at once.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count <= 16'h0000;
      enable_o <= 1'b0;
    end else if (count >= ratio_i) begin
      count <= 16'h0000;
      enable_o <= 1'b1;
    end else begin
      count <= count + 16'h0001;
      enable_o <= 1'b0;
    end
  end

  property p_div_gap;
    @(posedge clock_i) disable iff (reset_i)
    (enable_o && ratio_i != 16'h0000 && $stable(ratio_i)) |=> !enable_o;
  endproperty
  a_div_gap: assert property (p_div_gap)
    else $error("Divider pulsed twice in a row with nonzero ratio.");

endmodule : clock_rate_divider

// ==== logic/switch_config_registers.sv ====
// Processor switch and interconnect configuration register banks.
`timescale 1ns/1ps

module switch_config_registers
  import switch_config_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic req_bank_i,
  input wire logic req_remote_i,
  input wire logic [7:0] req_addr_i,
  input wire logic [31:0] req_wdata_i,
  output logic rsp_valid_o,
  output logic rsp_err_o,
  output logic [31:0] rsp_rdata_o,
  input wire logic [7:0] mode_pins_i,
  input wire logic [31:0] security_word_i,
  input wire logic [7:0][31:0] thread_pc_i,
  input wire logic [7:0][31:0] thread_sr_i,
  output logic debug_irq_o,
  output logic switch_debug_write_block_o,
  output logic short_headers_o,
  output logic [15:0] node_id_o,
  output logic [5:0] pll_ref_div_o,
  output logic [12:0] pll_fb_div_o,
  output logic [2:0] pll_out_div_o,
  output logic [7:0][3:0] routing_direction_o,
  output logic core_clk_en_o,
  output logic switch_clk_en_o,
  output logic ref_clk_en_o
);

  access_state_e state;
  access_state_e next_state;
  logic hold_write;
  logic hold_bank;
  logic hold_remote;
  logic [7:0] hold_addr;
  logic [31:0] hold_wdata;

  logic [31:0] core_perm;
  logic [31:0] core_clk_div;
  logic [7:0][31:0] scratch;
  logic [31:0] node_cfg;
  logic [15:0] node_id;
  logic [31:0] pll_ctrl;
  logic [15:0] sw_ratio;
  logic [15:0] ref_ratio;
  logic [31:0] directions;
  logic [7:0] mode_capture;

  logic deciding;
  logic core_wr;
  logic node_wr;
  logic remote_refused;
  logic core_frozen;
  logic node_frozen;
  logic hit;
  logic [31:0] read_word;

  // Sequencer: take, decode, reply. One access in flight keeps it simple.
  always_comb begin
    case (state)
      ST_IDLE: next_state = req_valid_i ? ST_DECODE : ST_IDLE;
      ST_DECODE: next_state = ST_REPLY;
      ST_REPLY: next_state = ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  assign req_ready_o = (state == ST_IDLE);
  assign rsp_valid_o = (state == ST_REPLY);
  assign deciding = (state == ST_DECODE);

  // Hold the request so the caller may drop it after the handshake.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      hold_write <= 1'b0;
      hold_bank <= BANK_CORE;
      hold_remote <= 1'b0;
      hold_addr <= 8'h00;
      hold_wdata <= 32'h0000_0000;
    end else if (req_valid_i && req_ready_o) begin
      hold_write <= req_write_i;
      hold_bank <= req_bank_i;
      hold_remote <= req_remote_i;
      hold_addr <= req_addr_i;
      hold_wdata <= req_wdata_i;
    end
  end

  // Mode pins are caught while reset is held and frozen after release.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mode_capture <= mode_pins_i;
    end
  end

  // Lock conditions; reads are never gated by the freeze bits.
  assign core_frozen = core_perm[PERM_FREEZE_BIT];
  assign node_frozen = node_cfg[CFG_FREEZE_BIT];
  assign remote_refused = (hold_bank == BANK_CORE) && hold_remote &&
                          core_perm[PERM_NO_REMOTE_BIT];
  assign core_wr = deciding && hold_write && (hold_bank == BANK_CORE) &&
                   !core_frozen && !remote_refused;
  assign node_wr = deciding && hold_write && (hold_bank == BANK_NODE) &&
                   !node_frozen;

  // Core permission register; only local writes may clear bit 8.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      core_perm <= CORE_PERM_RESET;
    end else if (core_wr && hold_addr == CORE_PERM_OFS) begin
      core_perm[PERM_NO_DBG_WRITE_BIT] <= hold_wdata[PERM_NO_DBG_WRITE_BIT];
      core_perm[PERM_NO_REMOTE_BIT] <= hold_wdata[PERM_NO_REMOTE_BIT] ||
        (hold_remote && core_perm[PERM_NO_REMOTE_BIT]);
      core_perm[PERM_FREEZE_BIT] <= hold_wdata[PERM_FREEZE_BIT];
    end
  end

  assign switch_debug_write_block_o = core_perm[PERM_NO_DBG_WRITE_BIT];

  // Core clock divider; the full word is kept but only 16 bits drive.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      core_clk_div <= CORE_CLK_DIV_RESET;
    end else if (core_wr && hold_addr == CORE_CLK_DIV_OFS) begin
      core_clk_div <= hold_wdata;
    end
  end

  // Scratch words for debug software, one per index.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_scratch
      always_ff @(posedge clock_i) begin
        if (reset_i) begin
          scratch[gi] <= 32'h0000_0000;
        end else if (core_wr &&
                     hold_addr == CORE_SCRATCH_OFS + 8'(gi)) begin
          scratch[gi] <= hold_wdata;
        end
      end
    end
  endgenerate

  // Debug interrupt pulse lines up with the reply cycle.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      debug_irq_o <= 1'b0;
    end else begin
      debug_irq_o <= core_wr && hold_addr == CORE_DBG_IRQ_OFS &&
                     hold_wdata[DBG_IRQ_BIT];
    end
  end

  // Node configuration; a freeze cannot be undone before reset.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      node_cfg <= NODE_CFG_RESET;
    end else if (node_wr && hold_addr == NODE_CFG_OFS) begin
      node_cfg[CFG_SHORT_HDR_BIT] <= hold_wdata[CFG_SHORT_HDR_BIT];
      node_cfg[CFG_PLL_LOCK_BIT] <= hold_wdata[CFG_PLL_LOCK_BIT];
      node_cfg[CFG_FREEZE_BIT] <= hold_wdata[CFG_FREEZE_BIT];
    end
  end

  assign short_headers_o = node_cfg[CFG_SHORT_HDR_BIT];

  // Node identifier, clock ratios and routing directions.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      node_id <= NODE_ID_RESET;
      sw_ratio <= SW_RATIO_RESET;
      ref_ratio <= REF_RATIO_RESET;
      directions <= DIR_RESET;
    end else if (node_wr) begin
      if (hold_addr == NODE_IDENT_OFS) begin
        node_id <= hold_wdata[15:0];
      end
      if (hold_addr == NODE_SW_RATIO_OFS) begin
        sw_ratio <= hold_wdata[15:0];
      end
      if (hold_addr == NODE_REF_RATIO_OFS) begin
        ref_ratio <= hold_wdata[15:0];
      end
      if (hold_addr == NODE_DIR_OFS) begin
        directions <= hold_wdata;
      end
    end
  end

  assign node_id_o = node_id;

  // PLL control; unused bits are dropped so they read back as zero.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pll_ctrl <= PLL_RESET;
    end else if (node_wr && hold_addr == NODE_PLL_OFS &&
                 !node_cfg[CFG_PLL_LOCK_BIT]) begin
      pll_ctrl <= 32'h0000_0000;
      pll_ctrl[PLL_REF_MSB:PLL_REF_LSB] <=
        hold_wdata[PLL_REF_MSB:PLL_REF_LSB];
      pll_ctrl[PLL_FB_MSB:PLL_FB_LSB] <= hold_wdata[PLL_FB_MSB:PLL_FB_LSB];
      pll_ctrl[PLL_OUT_MSB:PLL_OUT_LSB] <=
        hold_wdata[PLL_OUT_MSB:PLL_OUT_LSB];
    end
  end

  assign pll_ref_div_o = pll_ctrl[PLL_REF_MSB:PLL_REF_LSB];
  assign pll_fb_div_o = pll_ctrl[PLL_FB_MSB:PLL_FB_LSB];
  assign pll_out_div_o = pll_ctrl[PLL_OUT_MSB:PLL_OUT_LSB];
  assign routing_direction_o = directions;

  // Read decode for both banks; hit flags unmapped offsets as errors.
  always_comb begin
    read_word = 32'h0000_0000;
    hit = 1'b1;
    if (hold_bank == BANK_CORE) begin
      if (hold_addr == CORE_ID_OFS) begin
        read_word = {node_id, CORE_REVISION, CORE_VERSION};
      end else if (hold_addr == CORE_RES_A_OFS) begin
        read_word = {NUM_CHANENDS, NUM_LOCKS, NUM_SYNCS,
                     NUM_THREADS};
      end else if (hold_addr == CORE_RES_B_OFS) begin
        read_word = {16'h0000, NUM_CLK_BLOCKS, NUM_TIMERS};
      end else if (hold_addr == CORE_PERM_OFS) begin
        read_word = core_perm;
      end else if (hold_addr == CORE_DBG_IRQ_OFS) begin
        read_word = 32'h0000_0000;
      end else if (hold_addr == CORE_CLK_DIV_OFS) begin
        read_word = core_clk_div;
      end else if (hold_addr == CORE_SECURITY_OFS) begin
        read_word = security_word_i;
      end else if (hold_addr[7:3] == CORE_SCRATCH_OFS[7:3]) begin
        read_word = scratch[hold_addr[2:0]];
      end else if (hold_addr[7:3] == CORE_PC_OFS[7:3]) begin
        read_word = thread_pc_i[hold_addr[2:0]];
      end else if (hold_addr[7:3] == CORE_SR_OFS[7:3]) begin
        read_word = thread_sr_i[hold_addr[2:0]];
      end else begin
        hit = 1'b0;
      end
    end else begin
      if (hold_addr == NODE_ID_REG_OFS) begin
        read_word = {8'h00, mode_capture, NODE_REVISION,
                     NODE_VERSION};
      end else if (hold_addr == NODE_RES_OFS) begin
        read_word = {8'h00, NUM_EXT_LINKS, NUM_CORES,
                     NUM_INT_LINKS};
      end else if (hold_addr == NODE_CFG_OFS) begin
        read_word = node_cfg;
      end else if (hold_addr == NODE_IDENT_OFS) begin
        read_word = {16'h0000, node_id};
      end else if (hold_addr == NODE_PLL_OFS) begin
        read_word = pll_ctrl;
      end else if (hold_addr == NODE_SW_RATIO_OFS) begin
        read_word = {16'h0000, sw_ratio};
      end else if (hold_addr == NODE_REF_RATIO_OFS) begin
        read_word = {16'h0000, ref_ratio};
      end else if (hold_addr == NODE_DIR_OFS) begin
        read_word = directions;
      end else begin
        hit = 1'b0;
      end
    end
  end

  // Reply data is registered; a refused access returns zero and error.
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      rsp_rdata_o <= 32'h0000_0000;
      rsp_err_o <= 1'b0;
    end else if (deciding) begin
      rsp_rdata_o <= (remote_refused || hold_write) ? 32'h0000_0000
                                                    : read_word;
      rsp_err_o <= !hit || remote_refused ||
                   (hold_write && hold_bank == BANK_CORE && core_frozen) ||
                   (hold_write && hold_bank == BANK_NODE && node_frozen);
    end
  end

  // Processor, switch and reference clock enables.
  clock_rate_divider u_core_div (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .ratio_i(core_clk_div[15:0]),
    .enable_o(core_clk_en_o)
  );

  clock_rate_divider u_switch_div (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .ratio_i(sw_ratio),
    .enable_o(switch_clk_en_o)
  );

  clock_rate_divider u_ref_div (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .ratio_i(ref_ratio),
    .enable_o(ref_clk_en_o)
  );

  property p_reply_time;
    @(posedge clock_i) disable iff (reset_i)
    (req_valid_i && req_ready_o) |-> ##2 rsp_valid_o;
  endproperty
  a_reply_time: assert property (p_reply_time)
    else $error("Reply did not come two cycles after the request.");

  property p_core_id;
    @(posedge clock_i) disable iff (reset_i)
    (rsp_valid_o && !rsp_err_o && !hold_write && hold_bank == BANK_CORE &&
     hold_addr == CORE_ID_OFS) |-> rsp_rdata_o[31:16] == node_id;
  endproperty
  a_core_id: assert property (p_core_id)
    else $error("Core ID word lacks the node number.");

  property p_core_freeze;
    @(posedge clock_i) disable iff (reset_i)
    (deciding && hold_write && hold_bank == BANK_CORE && core_frozen)
      |=> $stable(core_perm) && $stable(core_clk_div) && !debug_irq_o;
  endproperty
  a_core_freeze: assert property (p_core_freeze)
    else $error("Frozen core bank changed on a write.");

  property p_remote_keep;
    @(posedge clock_i) disable iff (reset_i)
    (deciding && hold_remote && hold_bank == BANK_CORE &&
     core_perm[PERM_NO_REMOTE_BIT]) |=> core_perm[PERM_NO_REMOTE_BIT];
  endproperty
  a_remote_keep: assert property (p_remote_keep)
    else $error("Remote access cleared the remote block bit.");

  property p_dbg_irq;
    @(posedge clock_i) disable iff (reset_i)
    (core_wr && hold_addr == CORE_DBG_IRQ_OFS && hold_wdata[DBG_IRQ_BIT])
      |=> debug_irq_o && rsp_valid_o ##1 !debug_irq_o;
  endproperty
  a_dbg_irq: assert property (p_dbg_irq)
    else $error("Debug interrupt pulse missing or too long.");

  property p_pll_lock;
    @(posedge clock_i) disable iff (reset_i)
    node_cfg[CFG_PLL_LOCK_BIT] |=> $stable(pll_ctrl);
  endproperty
  a_pll_lock: assert property (p_pll_lock)
    else $error("PLL control changed while locked.");

  property p_node_freeze;
    @(posedge clock_i) disable iff (reset_i)
    node_frozen |=> node_frozen && $stable(node_id) && $stable(directions);
  endproperty
  a_node_freeze: assert property (p_node_freeze)
    else $error("Frozen node bank changed.");

  property p_mode_hold;
    @(posedge clock_i) disable iff (reset_i)
    !$past(reset_i) |-> $stable(mode_capture);
  endproperty
  a_mode_hold: assert property (p_mode_hold)
    else $error("Captured mode pins changed after reset.");

  property p_short_hdr;
    @(posedge clock_i) disable iff (reset_i)
    (node_wr && hold_addr == NODE_CFG_OFS)
      |=> short_headers_o == $past(hold_wdata[CFG_SHORT_HDR_BIT]);
  endproperty
  a_short_hdr: assert property (p_short_hdr)
    else $error("Short header output did not follow the write.");

endmodule : switch_config_registers

// ==== bench/access_agent.sv ====
// Request agent standing in for the debugger or the message sender.
`timescale 1ns/1ps
module access_agent (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic go_i,
  input wire logic [42:0] cmd_i,
  input wire logic req_ready_i,
  input wire logic rsp_valid_i,
  input wire logic rsp_err_i,
  input wire logic [31:0] rsp_rdata_i,
  output logic req_valid_o,
  output logic req_write_o,
  output logic req_bank_o,
  output logic req_remote_o,
  output logic [7:0] req_addr_o,
  output logic [31:0] req_wdata_o,
  output logic done_o,
  output logic err_o,
  output logic [31:0] rdata_o
);
  logic busy;

  // Hold the request until ready is sampled, then scramble the lines.
  // Inverting released lines keeps a sloppy decoder from living on stale data.
  always @(posedge clock_i) begin
    done_o <= 1'b0;
    if (reset_i) begin
      req_valid_o <= 1'b0;
      busy <= 1'b0;
      err_o <= 1'b0;
      rdata_o <= '0;
      {req_write_o, req_bank_o, req_remote_o, req_addr_o, req_wdata_o} <= '0;
    end else if (go_i && !busy) begin
      req_valid_o <= 1'b1;
      busy <= 1'b1;
      {req_write_o, req_bank_o, req_remote_o, req_addr_o, req_wdata_o} <= cmd_i;
    end else if (req_valid_o && req_ready_i) begin
      req_valid_o <= 1'b0;
      {req_write_o, req_bank_o, req_remote_o, req_addr_o, req_wdata_o} <=
        ~{req_write_o, req_bank_o, req_remote_o, req_addr_o, req_wdata_o};
    end else if (busy && rsp_valid_i) begin
      busy <= 1'b0;
      done_o <= 1'b1;
      err_o <= rsp_err_i;
      rdata_o <= rsp_rdata_i;
    end
  end
endmodule : access_agent

// ==== bench/tb_switch_config_registers.sv ====
// Self-checking bench for the switch configuration register banks.
`timescale 1ns/1ps
module tb_switch_config_registers;
  import switch_config_pkg::*;
  logic clock_i = 1'b0;
  logic reset_i = 1'b1;
  logic go = 1'b0;
  logic [42:0] cmd = '0;
  logic [7:0] mode_pins = 8'h00;
  logic [31:0] security = '0;
  logic [7:0][31:0] thread_pc = '0;
  logic [7:0][31:0] thread_sr = '0;
  logic req_valid, req_ready, req_write, req_bank, req_remote;
  logic [7:0] req_addr;
  logic [31:0] req_wdata, rsp_rdata, got;
  logic rsp_valid, rsp_err, done, got_err, irq, blk, short_hdr;
  logic core_en, sw_en, ref_en;
  logic [15:0] node_id;
  logic [5:0] ref_div;
  logic [12:0] fb_div;
  logic [2:0] out_div;
  logic [7:0][3:0] dirs;
  logic [31:0] seed = 32'd53616;
  logic [31:0] sc [8];
  logic [31:0] d, nid;
  logic [7:0] pins_rst;
  int err_total = 0;
  int num_checks = 0;
  int irq_count = 0;
  int cycles = 0;

  switch_config_registers DUT (.clock_i(clock_i), .reset_i(reset_i),
    .req_valid_i(req_valid), .req_ready_o(req_ready), .req_write_i(req_write),
    .req_bank_i(req_bank), .req_remote_i(req_remote), .req_addr_i(req_addr),
    .req_wdata_i(req_wdata), .rsp_valid_o(rsp_valid), .rsp_err_o(rsp_err),
    .rsp_rdata_o(rsp_rdata), .mode_pins_i(mode_pins),
    .security_word_i(security), .thread_pc_i(thread_pc),
    .thread_sr_i(thread_sr), .debug_irq_o(irq),
    .switch_debug_write_block_o(blk), .short_headers_o(short_hdr),
    .node_id_o(node_id), .pll_ref_div_o(ref_div), .pll_fb_div_o(fb_div),
    .pll_out_div_o(out_div), .routing_direction_o(dirs),
    .core_clk_en_o(core_en), .switch_clk_en_o(sw_en), .ref_clk_en_o(ref_en));

  access_agent agent (.clock_i(clock_i), .reset_i(reset_i), .go_i(go),
    .cmd_i(cmd), .req_ready_i(req_ready), .rsp_valid_i(rsp_valid),
    .rsp_err_i(rsp_err), .rsp_rdata_i(rsp_rdata), .req_valid_o(req_valid),
    .req_write_o(req_write), .req_bank_o(req_bank), .req_remote_o(req_remote),
    .req_addr_o(req_addr), .req_wdata_o(req_wdata), .done_o(done),
    .err_o(got_err), .rdata_o(got));

  // Clock at 20 MHz.
  always #25 clock_i = ~clock_i;

  // Count debug interrupt pulses and cut a hung run short.
  always @(posedge clock_i) begin
    if (irq === 1'b1) irq_count++;
    cycles++;
    if (cycles == 20000) begin
      err_total++;
      results();
    end
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  // Expected PLL outputs for a written word; other bits are dropped.
  function automatic logic [31:0] pll_exp(input logic [31:0] w);
    return {10'h0, w[25:23], w[20:8], w[5:0]};
  endfunction : pll_exp

  function automatic logic pick(input int sel);
    return (sel == 0) ? core_en : (sel == 1) ? sw_en : ref_en;
  endfunction : pick

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One access through the agent; a random idle gap varies the spacing.
  task automatic acc(input logic w, input logic b, input logic r,
                     input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    repeat (rnd() % 3) @(posedge clock_i);
    @(posedge clock_i);
    go <= 1'b1;
    cmd <= {w, b, r, a, wd};
    @(posedge clock_i);
    go <= 1'b0;
    do begin
      @(posedge clock_i);
      #1;
      n++;
    end while (done !== 1'b1 && n < 20);
    check({31'h0, done}, 32'h1);
  endtask : acc

  // Cycles between two enable pulses of the selected divider.
  task automatic period(input int sel, input logic [31:0] exp);
    int n;
    for (int k = 0; k < 2; k++) begin
      n = 0;
      do begin
        @(posedge clock_i);
        #1;
        n++;
      end while (pick(sel) !== 1'b1 && n < 100);
    end
    check(32'(n), exp);
  endtask : period

  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : results

  // Main sequence: identification, copies, writable fields, locks.
  initial begin
    mode_pins = 8'(rnd());
    pins_rst = mode_pins;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    mode_pins <= ~pins_rst;
    security <= rnd();
    for (int i = 0; i < 8; i++) begin
      thread_pc[i] <= rnd();
      thread_sr[i] <= rnd();
    end
    acc(0, BANK_CORE, 0, CORE_ID_OFS, 0);
    check(got, {16'h0, CORE_REVISION, CORE_VERSION});
    acc(0, BANK_CORE, 1, CORE_RES_A_OFS, 0);
    check(got, {NUM_CHANENDS, NUM_LOCKS, NUM_SYNCS, NUM_THREADS});
    acc(0, BANK_CORE, 0, CORE_RES_B_OFS, 0);
    check(got, {16'h0, NUM_CLK_BLOCKS, NUM_TIMERS});
    acc(0, BANK_NODE, 0, NODE_ID_REG_OFS, 0);
    check(got, {8'h0, pins_rst, NODE_REVISION, NODE_VERSION});
    acc(0, BANK_NODE, 1, NODE_RES_OFS, 0);
    check(got, {8'h0, NUM_EXT_LINKS, NUM_CORES, NUM_INT_LINKS});
    acc(0, BANK_CORE, 0, CORE_SECURITY_OFS, 0);
    check(got, security);
    for (int i = 0; i < 8; i++) begin
      acc(0, BANK_CORE, i[0], CORE_PC_OFS | 8'(i), 0);
      check(got, thread_pc[i]);
      acc(0, BANK_CORE, 0, CORE_SR_OFS | 8'(i), 0);
      check(got, thread_sr[i]);
      sc[i] = rnd();
      acc(1, BANK_CORE, i[1], CORE_SCRATCH_OFS | 8'(i), sc[i]);
    end
    for (int i = 0; i < 8; i++) begin
      acc(0, BANK_CORE, i[0], CORE_SCRATCH_OFS | 8'(i), 0);
      check(got, sc[i]);
    end
    acc(1, BANK_CORE, 0, 8'h10, rnd());
    check({31'h0, got_err}, 32'h1);
    acc(0, BANK_CORE, 0, 8'h10, 0);
    check({got[30:0], got_err}, 32'h1);
    nid = rnd();
    acc(1, BANK_NODE, 1, NODE_IDENT_OFS, nid);
    check({16'h0, node_id}, {16'h0, nid[15:0]});
    acc(0, BANK_NODE, 0, NODE_IDENT_OFS, 0);
    check(got, {16'h0, nid[15:0]});
    acc(0, BANK_CORE, 0, CORE_ID_OFS, 0);
    check(got, {nid[15:0], CORE_REVISION, CORE_VERSION});
    period(2, 4);
    acc(1, BANK_NODE, 0, NODE_SW_RATIO_OFS, (rnd() & 32'hffff_0000) | 32'h1);
    period(1, 2);
    acc(1, BANK_CORE, 0, CORE_CLK_DIV_OFS, {rnd() & 32'hffff_0000} | 32'h2);
    period(0, 3);
    acc(1, BANK_NODE, 0, NODE_REF_RATIO_OFS, 32'h0);
    period(2, 1);
    d = rnd();
    acc(1, BANK_NODE, 0, NODE_PLL_OFS, d);
    check({10'h0, out_div, fb_div, ref_div}, pll_exp(d));
    acc(1, BANK_NODE, 0, NODE_CFG_OFS, 32'h0000_0101);
    check({31'h0, short_hdr}, 32'h1);
    acc(1, BANK_NODE, 0, NODE_PLL_OFS, ~d);
    check({10'h0, out_div, fb_div, ref_div}, pll_exp(d));
    check({31'h0, got_err}, 32'h0);
    d = rnd();
    acc(1, BANK_NODE, 1, NODE_DIR_OFS, d);
    check(dirs, d);
    acc(1, BANK_CORE, 0, CORE_PERM_OFS, 32'h1);
    check({31'h0, blk}, 32'h1);
    acc(1, BANK_CORE, 0, CORE_PERM_OFS, 32'h100);
    check({31'h0, blk}, 32'h0);
    acc(0, BANK_CORE, 1, CORE_SCRATCH_OFS, 0);
    check({got[30:0], got_err}, 32'h1);
    acc(1, BANK_CORE, 1, CORE_PERM_OFS, 32'h0);
    check({31'h0, got_err}, 32'h1);
    acc(0, BANK_CORE, 0, CORE_PERM_OFS, 0);
    check(got, 32'h100);
    acc(1, BANK_CORE, 0, CORE_PERM_OFS, 32'h0);
    acc(0, BANK_CORE, 1, CORE_SCRATCH_OFS | 8'h1, 0);
    check(got, sc[1]);
    d = 32'(irq_count);
    acc(1, BANK_CORE, 0, CORE_DBG_IRQ_OFS, 32'h1);
    acc(1, BANK_CORE, 1, CORE_DBG_IRQ_OFS, 32'hffff_fffe);
    check(32'(irq_count) - d, 32'h1);
    acc(1, BANK_CORE, 0, CORE_PERM_OFS, 32'h8000_0000);
    acc(1, BANK_CORE, 0, CORE_SCRATCH_OFS, ~sc[0]);
    check({31'h0, got_err}, 32'h1);
    acc(0, BANK_CORE, 0, CORE_SCRATCH_OFS, 0);
    check({got_err, got}, {1'b0, sc[0]});
    acc(1, BANK_CORE, 0, CORE_PERM_OFS, 32'h0);
    acc(0, BANK_CORE, 0, CORE_PERM_OFS, 0);
    check(got, 32'h8000_0000);
    acc(1, BANK_NODE, 0, NODE_CFG_OFS, 32'h8000_0101);
    acc(1, BANK_NODE, 0, NODE_IDENT_OFS, ~nid);
    check({got_err, 15'h0, node_id}, {1'b1, 15'h0, nid[15:0]});
    acc(0, BANK_NODE, 0, NODE_CFG_OFS, 0);
    check(got, 32'h8000_0101);
    @(posedge clock_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge clock_i);
    reset_i <= 1'b0;
    acc(0, BANK_CORE, 0, CORE_PERM_OFS, 0);
    check(got, 32'h0);
    acc(0, BANK_NODE, 0, NODE_CFG_OFS, 0);
    check(got, 32'h0);
    results();
  end
endmodule : tb_switch_config_registers
